/* core/uief_regs.vh */
// Register map, field positions and timing constants of the USB interrupt and error flag block
// Operation
// - Device mode: set stall-sent flag, bit 7, when a STALL handshake is sent.
// - Set resume flag, bit 5, after K-state seen for 2.5 us.
// - Set bus-idle flag, bit 4, after constant idle for 3 ms or more.
// - Set token-done flag, bit 3; clearing it advances the transfer status FIFO.
// - Error summary, bit 1, read-only, set only by enabled error flags.
// - Device mode: bus-reset flag, bit 0, after 2.5 us reset; once per reset.
// - Host mode: attach flag, bit 6, when bus state is not SE0.
// - Host mode: detach flag, bit 0; not set again until reset state clears.
// - Hardware sets flags; writing one clears a flag, zero leaves it.
// - Upper byte of status and enable registers always reads zero.
// - Enable bit one enables its flag; bit 0 reset/detach; bit 6 host only.
// - Set bit-stuff error, error bit 7, on stuffing violation.
// - Set transfer overrun, error bit 5, when bytes exceed descriptor count; truncate.
// - Set turnaround timeout, error bit 4, on bus turnaround time-out.
// - Set field-size error, error bit 3, when data field not whole bytes.
// - Set data CRC error, error bit 2, on CRC16 failure.
// - Error bit 1: token CRC5 error in device mode, end-of-frame error in host.
// - Set PID check error, error bit 0, on PID check failure.
`ifndef UIEF_REGS_VH
`define UIEF_REGS_VH
`define UIEF_OFS_INT_STATUS 12'h000
`define UIEF_OFS_INT_ENABLE 12'h004
`define UIEF_OFS_ERR_STATUS 12'h008
`define UIEF_OFS_ERR_ENABLE 12'h00C
`define UIEF_OFS_MODE 12'h010
`define UIEF_BIT_STALL 7
`define UIEF_BIT_ATTACH 6
`define UIEF_BIT_RESUME 5
`define UIEF_BIT_IDLE 4
`define UIEF_BIT_TOKEN 3
`define UIEF_BIT_SOF 2
`define UIEF_BIT_ERRSUM 1
`define UIEF_BIT_RESET 0
`define UIEF_BIT_E_STUFF 7
`define UIEF_BIT_E_OVERRUN 5
`define UIEF_BIT_E_TURN 4
`define UIEF_BIT_E_FIELD 3
`define UIEF_BIT_E_CRC16 2
`define UIEF_BIT_E_CRC5EOF 1
`define UIEF_BIT_E_PID 0
`define UIEF_ERR_IMPL 8'hBF
`define UIEF_INT_DEV_IMPL 8'hBF
`define UIEF_INT_HOST_IMPL 8'hFF
`define UIEF_RST_VAL 8'h00
`define UIEF_CLK_HZ 20000000
`define UIEF_KSTATE_NS 2500
`define UIEF_URST_NS 2500
`define UIEF_IDLE_MS 3
`endif

/* core/uief_flags.v */
// USB interrupt and error flag registers with an AHB-Lite slave port
`timescale 1ns/1ps
`include "uief_regs.vh"
module uief_flags #(
  parameter IDLE_CYCLES = (`UIEF_IDLE_MS * (`UIEF_CLK_HZ / 1000))
) (
  input wire core_clk,
  input wire rstn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire usb_dp,
  input wire usb_dm,
  input wire low_speed,
  input wire stall_sent,
  input wire token_done,
  input wire sof_event,
  input wire bit_stuff_event,
  input wire overrun_event,
  input wire turnaround_event,
  input wire field_size_event,
  input wire data_crc_event,
  input wire crc5_eof_event,
  input wire pid_event,
  output wire truncate_rx,
  output reg status_fifo_advance,
  output wire host_mode,
  output wire usb_irq
);
  localparam KSTATE_CYCLES = (`UIEF_KSTATE_NS * (`UIEF_CLK_HZ / 1000000) + 999) / 1000;
  localparam URST_CYCLES = (`UIEF_URST_NS * (`UIEF_CLK_HZ / 1000000) + 999) / 1000;
  localparam KW = 8;
  localparam IW = 17;
  localparam [IW-1:0] IDLE_CNT = IDLE_CYCLES[IW-1:0];
  localparam [KW-1:0] K_CNT = KSTATE_CYCLES[KW-1:0];
  localparam [KW-1:0] R_CNT = URST_CYCLES[KW-1:0];

  reg [7:0] int_status_r;
  reg [7:0] int_enable;
  reg [7:0] err_status;
  reg [7:0] err_enable;
  reg mode_host;
  reg [1:0] dp_sync;
  reg [1:0] dm_sync;
  reg [KW-1:0] k_count;
  reg [KW-1:0] se0_count;
  reg [IW-1:0] idle_count;
  reg k_done;
  reg idle_done;
  reg reset_held;
  reg attach_seen;
  reg wr_pend;
  reg [11:0] wr_addr;

  // Summary flag is derived, never stored
  wire err_sum = |(err_status & err_enable);
  wire [7:0] impl_mask = mode_host ? `UIEF_INT_HOST_IMPL : `UIEF_INT_DEV_IMPL;
  wire [7:0] int_status = (int_status_r & impl_mask) | ({7'h00, err_sum} << `UIEF_BIT_ERRSUM);
  wire dp = dp_sync[1];
  wire dm = dm_sync[1];
  wire line_se0 = ~dp & ~dm;
  wire line_k = low_speed ? (dp & ~dm) : (~dp & dm);
  wire line_j = low_speed ? (~dp & dm) : (dp & ~dm);
  wire addr_phase = hsel & hready & htrans[1];

  function [7:0] clear_mask;
    input [11:0] a;
    input [11:0] ofs;
    input pend;
    input [31:0] d;
    begin
      clear_mask = (pend && a == ofs) ? d[7:0] : 8'h00;
    end
  endfunction

  wire [7:0] int_clr = clear_mask(wr_addr, `UIEF_OFS_INT_STATUS, wr_pend, hwdata);
  wire [7:0] err_clr = clear_mask(wr_addr, `UIEF_OFS_ERR_STATUS, wr_pend, hwdata);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign host_mode = mode_host;
  assign truncate_rx = overrun_event;
  assign usb_irq = |(int_status & int_enable);

  // Bus pins come from the transceiver domain
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dp_sync <= 2'b00;
      dm_sync <= 2'b00;
    end else begin
      dp_sync <= {dp_sync[0], usb_dp};
      dm_sync <= {dm_sync[0], usb_dm};
    end
  end

  // Line state timers; each flag fires once per stable episode
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      k_count <= {KW{1'b0}};
      se0_count <= {KW{1'b0}};
      idle_count <= {IW{1'b0}};
      k_done <= 1'b0;
      idle_done <= 1'b0;
      reset_held <= 1'b0;
      attach_seen <= 1'b0;
    end else begin
      if (!line_k) begin
        k_count <= {KW{1'b0}};
        k_done <= 1'b0;
      end else if (k_count != K_CNT) begin
        k_count <= k_count + 1'b1;
      end else begin
        k_done <= 1'b1;
      end
      if (!line_se0) begin
        se0_count <= {KW{1'b0}};
        reset_held <= 1'b0;
      end else if (se0_count != R_CNT) begin
        se0_count <= se0_count + 1'b1;
      end else begin
        reset_held <= 1'b1;
      end
      if (!line_j) begin
        idle_count <= {IW{1'b0}};
        idle_done <= 1'b0;
      end else if (idle_count != IDLE_CNT) begin
        idle_count <= idle_count + 1'b1;
      end else begin
        idle_done <= 1'b1;
      end
      attach_seen <= ~line_se0;
    end
  end

  wire k_fire = line_k & (k_count == K_CNT) & ~k_done;
  wire idle_fire = line_j & (idle_count == IDLE_CNT) & ~idle_done;
  // Held off until the SE0 episode ends, so it fires once per reset
  wire rst_fire = line_se0 & (se0_count == R_CNT) & ~reset_held;
  wire attach_fire = mode_host & ~line_se0 & ~attach_seen;

  wire [7:0] int_set = {stall_sent & ~mode_host,
                        attach_fire,
                        k_fire,
                        idle_fire,
                        token_done,
                        sof_event,
                        1'b0,
                        rst_fire};
  wire [7:0] err_set = {bit_stuff_event,
                        1'b0,
                        overrun_event,
                        turnaround_event,
                        field_size_event,
                        data_crc_event,
                        crc5_eof_event,
                        pid_event};

  // AHB data phase follows the registered address phase
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pend <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr <= {haddr[11:2], 2'b00};
      end
    end
  end

  // Set wins over a clear landing in the same cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      int_status_r <= `UIEF_RST_VAL;
      err_status <= `UIEF_RST_VAL;
      int_enable <= `UIEF_RST_VAL;
      err_enable <= `UIEF_RST_VAL;
      mode_host <= 1'b0;
      status_fifo_advance <= 1'b0;
    end else begin
      int_status_r <= ((int_status_r & ~int_clr) | int_set) & impl_mask;
      err_status <= ((err_status & ~err_clr) | err_set) & `UIEF_ERR_IMPL;
      status_fifo_advance <= int_clr[`UIEF_BIT_TOKEN] & int_status_r[`UIEF_BIT_TOKEN];
      if (wr_pend && wr_addr == `UIEF_OFS_INT_ENABLE) begin
        int_enable <= hwdata[7:0];
      end
      if (wr_pend && wr_addr == `UIEF_OFS_ERR_ENABLE) begin
        err_enable <= hwdata[7:0] & `UIEF_ERR_IMPL;
      end
      if (wr_pend && wr_addr == `UIEF_OFS_MODE) begin
        mode_host <= hwdata[0];
      end
    end
  end

  // Read data registered at the end of the data phase's first edge
  // Limitation: a read pipelined straight behind a write sees the old value
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `UIEF_OFS_INT_STATUS: hrdata <= {24'h000000, int_status};
        `UIEF_OFS_INT_ENABLE: hrdata <= {24'h000000, int_enable};
        `UIEF_OFS_ERR_STATUS: hrdata <= {24'h000000, err_status};
        `UIEF_OFS_ERR_ENABLE: hrdata <= {24'h000000, err_enable};
        `UIEF_OFS_MODE: hrdata <= {31'h00000000, mode_host};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end
endmodule // uief_flags

/* dv/uief_bus_model.sv */
// Far-side line driver putting J, K or SE0 on the bus lines
`timescale 1ns/1ps
module uief_bus_model (
  input wire logic [1:0] st,
  input wire logic low_speed,
  output logic dp,
  output logic dm
);
  // Low speed swaps J and K, so both speeds reach the K detector
  always_comb begin
    case (st)
      2'h2: {dp, dm} = 2'h0;
      2'h1: {dp, dm} = low_speed ? 2'h2 : 2'h1;
      default: {dp, dm} = low_speed ? 2'h1 : 2'h2;
    endcase
  end
endmodule // uief_bus_model

/* dv/uief_flags_sva.sv */
// Port-level checks for the USB interrupt and error flag block
`timescale 1ns/1ps
module uief_flags_sva (
  input wire core_clk,
  input wire rstn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire overrun_event,
  input wire truncate_rx,
  input wire status_fifo_advance,
  input wire host_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic wp;
  logic rp;
  logic rp2;
  logic [11:0] ad;
  wire ap = hsel && hready && htrans[1];
  wire clr3 = wp && ad == 12'h000 && hwdata[3];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp <= 1'h0;
      rp <= 1'h0;
      rp2 <= 1'h0;
      ad <= 12'h000;
    end else begin
      wp <= ap && hwrite;
      rp <= ap && !hwrite;
      rp2 <= rp;
      if (ap) ad <= {haddr[11:2], 2'h0};
    end
  end
  a_trunc_copy: assert property (truncate_rx == overrun_event)
    else $error("truncate differs from overrun");
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("wait state or error response");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_adv_cause: assert property (status_fifo_advance |-> $past(clr3) || $past(clr3, 2))
    else $error("fifo advance without token clear");
  a_adv_pulse: assert property (status_fifo_advance |=> !status_fifo_advance)
    else $error("fifo advance longer than one cycle");
  a_rd_hold: assert property (!rp && !rp2 |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_dev_attach: assert property (rp && ad == 12'h000 && !host_mode |-> !hrdata[6])
    else $error("attach bit set in device mode");
  a_unmapped_zero: assert property (rp && ad > 12'h010 |-> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  c_adv: cover property (status_fifo_advance);
  c_err_read: cover property (rp && ad == 12'h008);
  c_host: cover property (rp && host_mode);
endmodule // uief_flags_sva

/* dv/uief_flags_test.sv */
// Self-checking bench for the USB interrupt and error flag block
`timescale 1ns/1ps
module uief_flags_test;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic hsel = 1'h0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic low_speed = 1'h0;
  logic [9:0] ev = 10'h000;
  logic [1:0] st = 2'h0;
  wire hreadyout, hresp, truncate_rx, status_fifo_advance, host_mode, usb_irq, dp, dm;
  wire [31:0] hrdata;
  int n_errors = 0;
  int n_checks = 0;
  int n_adv = 0;
  initial forever #25 core_clk = ~core_clk;
  uief_bus_model far (.st(st), .low_speed(low_speed), .dp(dp), .dm(dm));
  uief_flags #(.IDLE_CYCLES(100)) dut (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .usb_dp(dp), .usb_dm(dm), .low_speed, .stall_sent(ev[6]),
    .token_done(ev[8]), .sof_event(ev[9]), .bit_stuff_event(ev[7]), .overrun_event(ev[5]), .turnaround_event(ev[4]),
    .field_size_event(ev[3]), .data_crc_event(ev[2]), .crc5_eof_event(ev[1]), .pid_event(ev[0]), .truncate_rx,
    .status_fifo_advance, .host_mode, .usb_irq);
  always @(posedge core_clk) if (status_fifo_advance === 1'h1) n_adv++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'h0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic pulse(input logic [9:0] v);
    ev <= v;
    @(posedge core_clk);
    ev <= 10'h000;
    @(posedge core_clk);
  endtask
  task automatic line(input logic [1:0] s, input int n);
    st <= s;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic irq_is(input logic [31:0] e);
    @(posedge core_clk);
    chk(32'(usb_irq), e);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 6; i++) rc(12'(i * 4), 32'hFFFFFFFF, 32'h0);
    wr(12'h004, 32'hFFFFFFBF);
    rc(12'h004, 32'hFFFFFFFF, 32'hBF);
    wr(12'h00C, 32'hFFFFFFBF);
    rc(12'h00C, 32'hFFFFFFFF, 32'hBF);
    wr(12'h014, 32'hFFFFFFFF);
    rc(12'h014, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_err;
    for (int i = 0; i < 8; i++) begin
      if (i == 6) continue;
      pulse(10'(1 << i));
      rc(12'h008, 32'hFFFFFFFF, 32'(1 << i));
      rc(12'h000, 32'h2, 32'h2);
      irq_is(32'h1);
      wr(12'h008, 32'(1 << i));
      rc(12'h008, 32'hFFFFFFFF, 32'h0);
      rc(12'h000, 32'h2, 32'h0);
    end
    wr(12'h00C, 32'h0);
    pulse(10'h005);
    rc(12'h000, 32'h2, 32'h0);
    wr(12'h008, 32'h1);
    rc(12'h008, 32'hFF, 32'h4);
  endtask
  task automatic t_int;
    int a;
    wr(12'h000, 32'hFF);
    pulse(10'h340);
    rc(12'h000, 32'h8C, 32'h8C);
    a = n_adv;
    wr(12'h000, 32'h8);
    repeat (3) @(posedge core_clk);
    chk(32'(n_adv - a), 32'h1);
    rc(12'h000, 32'h8C, 32'h84);
    wr(12'h004, 32'h0);
    irq_is(32'h0);
  endtask
  task automatic t_line;
    for (int s = 0; s < 2; s++) begin
      low_speed <= s[0];
      line(2'h0, 5);
      wr(12'h000, 32'hFF);
      line(2'h1, 40);
      rc(12'h000, 32'h20, 32'h0);
      line(2'h1, 20);
      rc(12'h000, 32'h20, 32'h20);
    end
    line(2'h2, 40);
    rc(12'h000, 32'h1, 32'h0);
    line(2'h2, 20);
    rc(12'h000, 32'h1, 32'h1);
    wr(12'h000, 32'h11);
    line(2'h2, 60);
    rc(12'h000, 32'h1, 32'h0);
    line(2'h0, 50);
    rc(12'h000, 32'h10, 32'h0);
    line(2'h0, 60);
    rc(12'h000, 32'h10, 32'h10);
    wr(12'h010, 32'h1);
    rc(12'h010, 32'hFF, 32'h1);
    chk(32'(host_mode), 32'h1);
    line(2'h2, 60);
    line(2'h0, 10);
    rc(12'h000, 32'h41, 32'h41);
    wr(12'h004, 32'h40);
    irq_is(32'h1);
    wr(12'h000, 32'h40);
    irq_is(32'h0);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    results;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'h1;
    @(posedge core_clk);
    t_regs;
    t_err;
    t_int;
    t_line;
    results;
  end
endmodule // uief_flags_test
bind uief_flags uief_flags_sva chk (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hresp, .hrdata, .overrun_event, .truncate_rx, .status_fifo_advance, .host_mode);
